// ---- hdl/rx_frame_filter_status.sv ----
// receive frame filter and per-frame status register with axi4-lite access
// assumes frame events come from receive logic on aclk; carrier_pin is async
`timescale 1ns/10ps
`default_nettype none
module rx_frame_filter_status #(
   parameter int WORD_W = 16
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   // axi4-lite slave
   input  wire logic [rx_filter_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [rx_filter_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // receive side
   input  wire logic                     carrier_pin,
   input  wire logic                     frame_start,
   input  wire logic                     frame_done,
   input  wire logic                     dest_table_hit,
   input  wire logic                     dest_is_group,
   input  wire logic                     dest_is_broadcast,
   input  wire logic                     frame_is_short,
   input  wire logic                     fcs_error,
   input  wire logic                     align_error,
   input  wire logic                     collision_seen,
   input  wire logic                     loopback_frame,
   input  wire logic [WORD_W-1:0]        remaining_buffer_words,
   input  wire logic [WORD_W-1:0]        end_of_buffer_threshold,
   // results
   output logic                          frame_accept,
   output logic                          frame_reject,
   output logic                          desc_status_valid,
   output logic [15:0]                   rx_descriptor_status_word,
   output rx_filter_pkg::loopback_t      loopback_mode,
   output logic                          irq
);

   // ---------------------------------------------------------------
   // register word index from a byte address
   // ---------------------------------------------------------------
   function automatic logic [5:0] word_index(input logic [rx_filter_pkg::ADDR_W-1:0] a);
      return a[7:2];
   endfunction

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [rx_filter_pkg::CTRL_W-1:0] ctrl;
   logic [rx_filter_pkg::STAT_W-1:0] stat;
   logic [rx_filter_pkg::CTRL_W-1:0] next_ctrl;
   logic [rx_filter_pkg::STAT_W-1:0] next_stat;
   logic [15:0]                      next_desc_word;
   logic                             carrier_meta;
   logic                             carrier_sync;
   logic                             accept;
   logic [rx_filter_pkg::STAT_W-1:0] frame_stat;
   // bus state
   logic                             aw_held;
   logic                             w_held;
   logic [5:0]                       aw_idx;
   logic [31:0]                      w_data;
   logic [3:0]                       w_strb;
   logic                             next_aw_held;
   logic                             next_w_held;
   logic [5:0]                       next_aw_idx;
   logic [31:0]                      next_w_data;
   logic [3:0]                       next_w_strb;
   logic                             next_bvalid;
   logic [1:0]                       next_bresp;
   logic                             next_rvalid;
   logic [1:0]                       next_rresp;
   logic [31:0]                      next_rdata;
   logic                             wr_go;
   logic [rx_filter_pkg::IRQ_W-1:0]  irq_stat;
   logic [rx_filter_pkg::IRQ_W-1:0]  irq_en;

   // ---------------------------------------------------------------
   // carrier pin synchroniser
   // ---------------------------------------------------------------
   // two flops, only the second is looked at
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         carrier_meta <= 1'b0;
         carrier_sync <= 1'b0;
      end else begin
         carrier_meta <= carrier_pin;
         carrier_sync <= carrier_meta;
      end
   end

   // ---------------------------------------------------------------
   // acceptance decision
   // ---------------------------------------------------------------
   rx_accept_decision u_decision (
      .accept_faulty (ctrl[rx_filter_pkg::BIT_ACCEPT_FAULTY - rx_filter_pkg::BIT_LOOP_LSB]),
      .accept_short  (ctrl[rx_filter_pkg::BIT_ACCEPT_SHORT - rx_filter_pkg::BIT_LOOP_LSB]),
      .accept_bcast  (ctrl[rx_filter_pkg::BIT_ACCEPT_BCAST - rx_filter_pkg::BIT_LOOP_LSB]),
      .accept_ucast  (ctrl[rx_filter_pkg::BIT_ACCEPT_UCAST - rx_filter_pkg::BIT_LOOP_LSB]),
      .accept_group  (ctrl[rx_filter_pkg::BIT_ACCEPT_GROUP - rx_filter_pkg::BIT_LOOP_LSB]),
      .table_hit     (dest_table_hit),
      .is_group      (dest_is_group),
      .is_bcast      (dest_is_broadcast),
      .is_short      (frame_is_short),
      .fcs_error     (fcs_error),
      .collision     (collision_seen),
      .accept        (accept)
   );

   // ---------------------------------------------------------------
   // status of the frame that just ended
   // ---------------------------------------------------------------
   // one bit per true condition
   always_comb begin
      frame_stat = rx_filter_pkg::RST_STAT;
      frame_stat[rx_filter_pkg::BIT_GROUP_SEEN] = dest_is_group;
      frame_stat[rx_filter_pkg::BIT_BCAST_SEEN] = dest_is_broadcast;
      frame_stat[rx_filter_pkg::BIT_FINAL_FRAME] = remaining_buffer_words < end_of_buffer_threshold;
      frame_stat[rx_filter_pkg::BIT_CARRIER]     = carrier_sync;
      frame_stat[rx_filter_pkg::BIT_COLLISION]   = collision_seen;
      // misalignment only reported with an fcs error, replacing it
      frame_stat[rx_filter_pkg::BIT_FCS_ERROR]   = fcs_error && !align_error;
      frame_stat[rx_filter_pkg::BIT_MISALIGNED]  = fcs_error && align_error;
      // loopback ok needs a clean frame while a loopback mode runs
      frame_stat[rx_filter_pkg::BIT_LOOPBACK_OK] = loopback_frame && (ctrl[1:0] != 2'h0)
                                                   && !fcs_error && !collision_seen;
      frame_stat[rx_filter_pkg::BIT_RX_OK]       = !fcs_error && !collision_seen;
   end

   // ---------------------------------------------------------------
   // rx_filter_and_status next value
   // ---------------------------------------------------------------
   // no software reset input reaches this register
   always_comb begin
      next_ctrl = ctrl;
      next_stat = stat;
      // only the upper byte lane holds writable bits
      if (wr_go && aw_idx == rx_filter_pkg::IDX_RX_FILTER && w_strb[1]) begin
         next_ctrl = w_data[15:9];
      end
      // an accepted finishing frame outranks a new one starting in the same cycle
      if (frame_done && accept) begin
         next_stat = frame_stat;
      end else if (frame_start) begin
         // carrier and collision survive a new frame
         next_stat = stat & rx_filter_pkg::STAT_KEEP_MASK;
      end
      // descriptor copy holds control and fresh status alike
      next_desc_word = {next_ctrl, next_stat};
   end

   // hardware reset clears control and status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl                      <= rx_filter_pkg::RST_CTRL;
         stat                      <= rx_filter_pkg::RST_STAT;
         frame_accept              <= 1'b0;
         frame_reject              <= 1'b0;
         desc_status_valid         <= 1'b0;
         rx_descriptor_status_word <= 16'h0000;
      end else begin
         ctrl                      <= next_ctrl;
         stat                      <= next_stat;
         frame_accept              <= frame_done && accept;
         frame_reject              <= frame_done && !accept;
         desc_status_valid         <= frame_done && accept;
         if (frame_done && accept) begin
            rx_descriptor_status_word <= next_desc_word;
         end
      end
   end

   // loopback field straight to its mode
   assign loopback_mode = rx_filter_pkg::loopback_t'(ctrl[1:0]);

   // ---------------------------------------------------------------
   // interrupt status, enable and clear
   // ---------------------------------------------------------------
   rx_irq_status #(
      .N (rx_filter_pkg::IRQ_W)
   ) u_irq (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .event_set ({frame_done && !accept, frame_done && accept}),
      .clear_wr  (wr_go && aw_idx == rx_filter_pkg::IDX_IRQ_CLEAR && w_strb[0]),
      .enable_wr (wr_go && aw_idx == rx_filter_pkg::IDX_IRQ_ENABLE && w_strb[0]),
      .wr_bits   (w_data[rx_filter_pkg::IRQ_W-1:0]),
      .status    (irq_stat),
      .enable    (irq_en),
      .irq       (irq)
   );

   // ---------------------------------------------------------------
   // axi4-lite write path
   // ---------------------------------------------------------------
   // address and data are taken in either order, one write at a time
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_go         = aw_held && w_held;

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_idx  = aw_idx;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_idx  = word_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (wr_go) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         // status is read-only, writes there are refused
         unique case (aw_idx)
            rx_filter_pkg::IDX_RX_FILTER,
            rx_filter_pkg::IDX_IRQ_ENABLE,
            rx_filter_pkg::IDX_IRQ_CLEAR: next_bresp = rx_filter_pkg::RESP_OKAY;
            default:                      next_bresp = rx_filter_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_idx       <= 6'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= rx_filter_pkg::RESP_OKAY;
      end else begin
         aw_held      <= next_aw_held;
         w_held       <= next_w_held;
         aw_idx       <= next_aw_idx;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp  <= next_bresp;
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read path
   // ---------------------------------------------------------------
   // one read in flight, answered the cycle after the address
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      next_rvalid = s_axi_rvalid;
      next_rresp  = s_axi_rresp;
      next_rdata  = s_axi_rdata;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = rx_filter_pkg::RESP_OKAY;
         unique case (word_index(s_axi_araddr))
            // control and live status in one word
            rx_filter_pkg::IDX_RX_FILTER:  next_rdata = {16'h0000, ctrl, stat};
            rx_filter_pkg::IDX_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_stat};
            rx_filter_pkg::IDX_IRQ_ENABLE: next_rdata = {30'h0000_0000, irq_en};
            rx_filter_pkg::IDX_IRQ_CLEAR:  next_rdata = 32'h0000_0000;
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = rx_filter_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= rx_filter_pkg::RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
      end else begin
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp  <= next_rresp;
         s_axi_rdata  <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_filter_default_table: assert property (
      (frame_done && ctrl[6:2] == 5'h00 && !dest_table_hit) |=> !frame_accept)
      else $error("frame accepted with filters off and no table hit");

   chk_status_capture: assert property (
      (frame_done && accept) |=> (stat == $past(frame_stat)))
      else $error("status bits not captured for accepted frame");

   chk_desc_copy: assert property (
      desc_status_valid |-> (rx_descriptor_status_word == {ctrl, stat}))
      else $error("descriptor word differs from register");

   chk_start_clears: assert property (
      (frame_start && !frame_done) |=> (stat == ($past(stat) & rx_filter_pkg::STAT_KEEP_MASK)))
      else $error("frame start cleared wrong status bits");

   chk_status_read_only: assert property (
      (wr_go && !frame_done && !frame_start) |=> $stable(stat))
      else $error("bus write changed status bits");

   chk_faulty_reject: assert property (
      (frame_done && !ctrl[6] && (fcs_error || collision_seen)) |=> frame_reject)
      else $error("faulty frame accepted with bit 15 clear");

   chk_runt_reject: assert property (
      (frame_done && !ctrl[5] && frame_is_short) |=> !frame_accept)
      else $error("short frame accepted with bit 14 clear");

   chk_group_all: assert property (
      (frame_done && ctrl[2] && dest_is_group && !frame_is_short && !fcs_error && !collision_seen)
      |=> frame_accept)
      else $error("multicast frame refused with bit 11 set");

   chk_loop_mode: assert property (
      (wr_go && aw_idx == rx_filter_pkg::IDX_RX_FILTER && w_strb[1])
      |=> (loopback_mode == rx_filter_pkg::loopback_t'($past(w_data[10:9]))))
      else $error("loopback mode does not follow its field");

   chk_misalign_only: assert property (
      !(stat[rx_filter_pkg::BIT_MISALIGNED] && stat[rx_filter_pkg::BIT_FCS_ERROR]))
      else $error("misaligned and fcs error set together");

   chk_write_answer: assert property (
      wr_go |=> (s_axi_bvalid && !aw_held && !w_held))
      else $error("write not answered one cycle after both halves");

endmodule
`default_nettype wire

// ---- hdl/rx_filter_pkg.sv ----
// constants shared by the receive filter/status block and its helpers
// assumes a 32-bit axi4-lite bus with byte addresses, one word per register
package rx_filter_pkg;

   // ---------------------------------------------------------------
   // register map: word indices, byte address is index times four
   // ---------------------------------------------------------------
   localparam int         ADDR_W          = 8;
   localparam logic [5:0] IDX_RX_FILTER   = 6'h02;
   localparam logic [5:0] IDX_IRQ_STATUS  = 6'h04;
   localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h05;
   localparam logic [5:0] IDX_IRQ_CLEAR   = 6'h06;

   // ---------------------------------------------------------------
   // rx_filter_and_status field layout
   // ---------------------------------------------------------------
   localparam int BIT_ACCEPT_FAULTY  = 15;
   localparam int BIT_ACCEPT_SHORT   = 14;
   localparam int BIT_ACCEPT_BCAST   = 13;
   localparam int BIT_ACCEPT_UCAST   = 12;
   localparam int BIT_ACCEPT_GROUP   = 11;
   localparam int BIT_LOOP_LSB       = 9;
   localparam int BIT_GROUP_SEEN     = 8;
   localparam int BIT_BCAST_SEEN     = 7;
   localparam int BIT_FINAL_FRAME    = 6;
   localparam int BIT_CARRIER        = 5;
   localparam int BIT_COLLISION      = 4;
   localparam int BIT_FCS_ERROR      = 3;
   localparam int BIT_MISALIGNED     = 2;
   localparam int BIT_LOOPBACK_OK    = 1;
   localparam int BIT_RX_OK          = 0;
   localparam int CTRL_W             = 7;
   localparam int STAT_W             = 9;
   localparam logic [STAT_W-1:0] STAT_KEEP_MASK = 9'h030;
   localparam logic [CTRL_W-1:0] RST_CTRL       = 7'h00;
   localparam logic [STAT_W-1:0] RST_STAT       = 9'h000;

   // ---------------------------------------------------------------
   // interrupt events and bus answers
   // ---------------------------------------------------------------
   localparam int         IRQ_ACCEPTED = 0;
   localparam int         IRQ_REJECTED = 1;
   localparam int         IRQ_W        = 2;
   localparam logic [1:0] IRQ_RST      = 2'h0;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {LOOP_NONE, LOOP_MAC, LOOP_CODEC, LOOP_XCVR} loopback_t;

endpackage

// ---- hdl/rx_accept_decision.sv ----
// acceptance decision for one received frame
// assumes frame attributes are stable while frame_done is high
`timescale 1ns/10ps
`default_nettype none
module rx_accept_decision (
   input  wire logic accept_faulty,
   input  wire logic accept_short,
   input  wire logic accept_bcast,
   input  wire logic accept_ucast,
   input  wire logic accept_group,
   input  wire logic table_hit,
   input  wire logic is_group,
   input  wire logic is_bcast,
   input  wire logic is_short,
   input  wire logic fcs_error,
   input  wire logic collision,
   output logic      accept
);
   logic addr_ok;
   logic short_ok;
   logic error_ok;

   // ---------------------------------------------------------------
   // address filters
   // ---------------------------------------------------------------
   // extra filters widen the table
   always_comb begin
      addr_ok = table_hit;
      if (is_bcast && accept_bcast) begin
         addr_ok = 1'b1;
      end
      if (is_group && accept_group) begin
         addr_ok = 1'b1;
      end
      if (!is_group && accept_ucast) begin
         addr_ok = 1'b1;
      end
   end

   assign short_ok = !is_short || accept_short;
   // faulty frames pass only when enabled
   assign error_ok = accept_faulty || (!fcs_error && !collision);
   assign accept = addr_ok && short_ok && error_ok;
endmodule
`default_nettype wire

// ---- hdl/rx_irq_status.sv ----
// sticky event status, enable mask and one level interrupt
// assumes event pulses and register writes come from the aclk domain
`timescale 1ns/10ps
`default_nettype none
module rx_irq_status #(
   parameter int N = 2
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [N-1:0] event_set,
   input  wire logic         clear_wr,
   input  wire logic         enable_wr,
   input  wire logic [N-1:0] wr_bits,
   output logic      [N-1:0] status,
   output logic      [N-1:0] enable,
   output logic              irq
);
   logic [N-1:0] next_status;
   logic [N-1:0] next_enable;

   // set wins over a clear in the same cycle, no event lost
   always_comb begin
      next_status = (clear_wr ? (status & ~wr_bits) : status) | event_set;
      next_enable = enable_wr ? wr_bits : enable;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= N'(0);
         enable <= N'(0);
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         enable <= next_enable;
         irq    <= |(next_status & next_enable);
      end
   end
endmodule
`default_nettype wire

// ---- verification/medium_model.sv ----
// medium model: raises frame start, then done with the frame's attributes
// assumes go is a one-cycle request launched just after an aclk edge
`timescale 1ns/10ps
`default_nettype none
module medium_model (
   input  wire logic       aclk,
   input  wire logic       go,
   input  wire logic [7:0] attr,
   output logic            frame_start,
   output logic            frame_done,
   output logic      [7:0] pins
);
   // attributes are only valid with done; elsewhere they toggle so stale values never pass
   initial begin
      frame_start = 1'b0;
      frame_done = 1'b0;
      pins = 8'h00;
   end
   always @(posedge aclk) begin
      frame_start <= go;
      frame_done  <= frame_start;
      pins        <= frame_start ? attr : ~pins;
   end
endmodule
`default_nettype wire

// ---- verification/test_rx_frame_filter_status.sv ----
// bench: axi4-lite register access, random frames and interrupt handling
// assumes the medium model file is compiled beforehand
`timescale 1ns/10ps
`default_nettype none
module test_rx_frame_filter_status;
   logic aclk, aresetn, awv, wv, bre, arv, rre, go, acc, rej, ok, cr;
   logic [3:0] ws;
   logic [7:0] awa, ara, at;
   logic [31:0] wd;
   logic [15:0] rem, c, last;
   logic [8:0] st, s;
   wire logic awr, wr, bv, arr, rv, fs, fd, fa, fr, dv, irq;
   wire logic [7:0] p;
   wire logic [1:0] br, rr;
   wire logic [31:0] rd;
   wire logic [15:0] dw;
   wire rx_filter_pkg::loopback_t lm;
   int num_errors, n_checks, n;
   logic [17:0] erd[$];
   logic [17:0] edw[$];
   rx_frame_filter_status rx_frame_filter_status_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rre), .carrier_pin(cr), .frame_start(fs), .frame_done(fd), .dest_table_hit(p[7]),
      .dest_is_group(p[6]), .dest_is_broadcast(p[5]), .frame_is_short(p[4]), .fcs_error(p[3]),
      .align_error(p[2]), .collision_seen(p[1]), .loopback_frame(p[0]), .remaining_buffer_words(rem),
      .end_of_buffer_threshold(16'h0100), .frame_accept(fa), .frame_reject(fr), .desc_status_valid(dv),
      .rx_descriptor_status_word(dw), .loopback_mode(lm), .irq(irq));
   medium_model medium_model_inst (.aclk(aclk), .go(go), .attr(at), .frame_start(fs), .frame_done(fd), .pins(p));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic cmp(input logic [17:0] g, input logic [17:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // every wait is bounded; a hang ends the run
   task automatic tick;
      @(negedge aclk);
      n++;
      if (n > 300) begin
         num_errors++;
         wrap_up();
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic ta, tw;
      n = 0;
      @(posedge aclk);
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
      do begin
         tick(); ta = awv & awr; tw = wv & wr;
         @(posedge aclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end while (awv | wv);
      do tick(); while (!bv);
      cmp({br, 16'h0}, {e, 16'h0});
      @(posedge aclk);
      bre <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [17:0] e);
      n = 0;
      erd.push_back(e);
      @(posedge aclk);
      ara <= a; arv <= 1'b1; rre <= 1'b1;
      do tick(); while (!arr);
      @(posedge aclk);
      arv <= 1'b0;
      do tick(); while (!rv);
      @(posedge aclk);
      rre <= 1'b0;
   endtask
   // monitor: results taken off the queues as they appear
   always @(negedge aclk) begin
      if (rv && rre) cmp({rr, rd[15:0]}, erd.pop_front());
      if (fa || fr) cmp({dv, fa, dw}, edw.pop_front());
   end
   // one random frame, expectation worked out beforehand
   task automatic frame;
      logic [7:0] a;
      logic [15:0] r;
      logic k;
      a = 8'($urandom);
      k = 1'($urandom);
      a[6] = a[6] | a[5];
      r = 16'($urandom) >> 7;
      s = {a[6], a[5], r < 16'h0100, k, a[1], a[3] & !a[2], a[3] & a[2],
           a[0] & (c[10:9] != 2'h0) & !a[3] & !a[1], !a[3] & !a[1]};
      ok = (a[7] | a[5] & c[13] | a[6] & c[11] | !a[6] & c[12]) & (!a[4] | c[14]) & (c[15] | !a[3] & !a[1]);
      st = ok ? s : st & 9'h030;
      if (ok) last = {c[15:9], s};
      edw.push_back({ok, ok, last});
      acc = acc | ok;
      rej = rej | !ok;
      @(posedge aclk);
      at <= a; rem <= r; go <= 1'b1; cr <= k;
      @(posedge aclk);
      go <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask
   initial begin
      {aresetn, awv, wv, bre, arv, rre, go, acc, rej, cr} = '0;
      ws = 4'hf;
      {awa, ara, at, wd, rem, last, st, num_errors, n_checks} = '0;
      n = $urandom(63);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(8'h08, 18'h0);
      rd_reg(8'h3c, 18'h20000);
      wr_reg(8'h10, 32'h3, 2'h2);
      wr_reg(8'h14, 32'h3, 2'h0);
      for (int i = 0; i < 60; i++) begin
         c = 16'($urandom);
         wr_reg(8'h08, {16'h0, c}, 2'h0);
         cmp({16'h0, lm}, {16'h0, c[10:9]});
         frame();
         rd_reg(8'h08, {2'h0, c[15:9], st});
      end
      ws <= 4'h1;
      wr_reg(8'h08, {16'h0, ~c}, 2'h0);
      rd_reg(8'h08, {2'h0, c[15:9], st});
      ws <= 4'hf;
      rd_reg(8'h10, {16'h0, rej, acc});
      cmp({17'h0, irq}, {17'h0, acc | rej});
      wr_reg(8'h14, 32'h0, 2'h0);
      tick(); tick();
      cmp({17'h0, irq}, 18'h0);
      wr_reg(8'h18, 32'h3, 2'h0);
      rd_reg(8'h10, 18'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
